// ### common/acr_map.vh
// acr_map.vh: register offsets, field positions, reset values and event bits
// for the analog control register bank; definitions only
`ifndef ACR_MAP_VH
`define ACR_MAP_VH

// printed offsets step by one, not by four: they are word indices
`define ACR_IDX_ADC_EN 16'h2864
`define ACR_IDX_AUX_CHOP 16'h2865
`define ACR_IDX_REG_CTRL 16'h2866
`define ACR_IDX_CLK_MUL 16'h2867
`define ACR_IDX_PLL_GRID 16'h2868
`define ACR_IDX_STATUS 16'h286b
`define ACR_IDX_IRQ_STAT 16'h286c
`define ACR_IDX_IRQ_MASK 16'h286d
`define ACR_ADDR_W 18

`define ACR_CTRL_RESET 8'h00
`define ACR_STATUS_FIXED 3'h5

// adc enable fields
`define ACR_CMP_EN_BIT 5
`define ACR_AUX_ADC_BIT 3
`define ACR_VOLT_ADC_BIT 2
`define ACR_CUR_B_ADC_BIT 1
`define ACR_CUR_A_ADC_BIT 0
// aux channel fields
`define ACR_CHOP_DIS_BIT 0
// regulator fields
`define ACR_PDET_DIS_BIT 7
`define ACR_BIAS_BOOST_BIT 6
`define ACR_VSEL_MSB 5
`define ACR_VSEL_LSB 3
`define ACR_TRIM_MSB 2
`define ACR_TRIM_LSB 0
// clock fields
`define ACR_PLL_EN_BIT 7
`define ACR_REF_EN_BIT 6
`define ACR_SMP_MSB 5
`define ACR_SMP_LSB 4
`define ACR_MET_MSB 3
`define ACR_MET_LSB 2
`define ACR_PROC_MSB 1
`define ACR_PROC_LSB 0
`define ACR_CLK_RESERVED 2'b11
// pll fields
`define ACR_QUAD_BIT 7
`define ACR_DBL_BIT 6
`define ACR_GRID_BIT 5
// status fields
`define ACR_XTAL_BIT 7
`define ACR_CMP_OUT_BIT 5
`define ACR_FIXED_LSB 2
// interrupt events
`define ACR_EV_XTAL_STOP 0
`define ACR_EV_CMP_RISE 1
`define ACR_EV_CMP_FALL 2
`define ACR_EV_W 3

`define ACR_RESP_OKAY 2'b00
`define ACR_RESP_SLVERR 2'b10

`endif

// ### logic/acr_bank.v
// acr_bank.v: analog control register bank on an axi4-lite slave port
// assumes srst synchronous to ref_clk and analog status inputs already synchronous
`timescale 1ns/1ps
`include "acr_map.vh"

module acr_bank (
  // clock and reset
  input wire ref_clk,
  input wire srst,
  // axi4-lite write address and data
  input wire [`ACR_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [`ACR_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // analog status inputs
  input wire crystal_stopped_in,
  input wire comparator_out_in,
  // analog controls
  output reg comparator_enable,
  output reg aux_adc_enable,
  output reg voltage_adc_enable,
  output reg current_b_adc_enable,
  output reg current_a_adc_enable,
  output reg aux_chopper_disable,
  output reg power_detect_disable,
  output reg regulator_bias_boost,
  output reg [2:0] regulator_voltage_select,
  output reg [2:0] digital_supply_trim,
  output reg pll_enable,
  output reg reference_enable,
  output reg [1:0] sample_clock_select,
  output reg [1:0] metering_clock_select,
  output reg [1:0] processor_clock_select,
  output reg [1:0] processor_clock_boost,
  output reg grid_frequency_select,
  // interrupt
  output reg irq
);

  ////////////////////////////////////////////////////////////////////////////
  reg [7:0] adc_enable_control_q;
  reg [7:0] aux_channel_chopper_control_q;
  reg [7:0] regulator_control_q;
  reg [7:0] clock_multiplier_control_q;
  reg [7:0] pll_grid_control_q;
  reg [`ACR_EV_W-1:0] irq_status_q;
  reg [`ACR_EV_W-1:0] irq_mask_q;
  reg crystal_prev_q;
  reg cmp_prev_q;
  reg aw_held_q;
  reg w_held_q;
  reg [`ACR_ADDR_W-1:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  wire [15:0] w_idx = awaddr_q[`ACR_ADDR_W-1:2];
  wire [15:0] r_idx = s_axi_araddr[`ACR_ADDR_W-1:2];
  wire do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  wire wr_lane0 = do_write && wstrb_q[0];
  wire do_read = s_axi_arvalid && s_axi_arready;
  wire read_stat = do_read && (r_idx == `ACR_IDX_IRQ_STAT);

  wire [7:0] status_value;
  assign status_value = {crystal_stopped_in, 1'b0, comparator_out_in,
    `ACR_STATUS_FIXED, 2'b00};

  wire [`ACR_EV_W-1:0] events;
  assign events[`ACR_EV_XTAL_STOP] = crystal_stopped_in && !crystal_prev_q;
  assign events[`ACR_EV_CMP_RISE] = comparator_out_in && !cmp_prev_q;
  assign events[`ACR_EV_CMP_FALL] = !comparator_out_in && cmp_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // fields of the control registers
  wire [1:0] sample_code = clock_multiplier_control_q[`ACR_SMP_MSB:`ACR_SMP_LSB];
  wire [1:0] metering_code = clock_multiplier_control_q[`ACR_MET_MSB:`ACR_MET_LSB];
  wire [1:0] processor_code = clock_multiplier_control_q[`ACR_PROC_MSB:`ACR_PROC_LSB];
  wire [2:0] voltage_code = regulator_control_q[`ACR_VSEL_MSB:`ACR_VSEL_LSB];
  wire [2:0] trim_code = regulator_control_q[`ACR_TRIM_MSB:`ACR_TRIM_LSB];
  wire double_req = pll_grid_control_q[`ACR_DBL_BIT];
  wire quad_req = pll_grid_control_q[`ACR_QUAD_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // next values of the analog outputs
  wire comparator_enable_d = adc_enable_control_q[`ACR_CMP_EN_BIT];
  wire aux_adc_enable_d = adc_enable_control_q[`ACR_AUX_ADC_BIT];
  wire voltage_adc_enable_d = adc_enable_control_q[`ACR_VOLT_ADC_BIT];
  wire current_b_adc_enable_d = adc_enable_control_q[`ACR_CUR_B_ADC_BIT];
  wire current_a_adc_enable_d = adc_enable_control_q[`ACR_CUR_A_ADC_BIT];
  wire aux_chopper_disable_d = aux_channel_chopper_control_q[`ACR_CHOP_DIS_BIT];
  wire power_detect_disable_d = regulator_control_q[`ACR_PDET_DIS_BIT];
  wire regulator_bias_boost_d = regulator_control_q[`ACR_BIAS_BOOST_BIT];
  wire [2:0] regulator_voltage_select_d = voltage_code;
  wire [2:0] digital_supply_trim_d = trim_code;
  // no ordering check: the analog side needs the reference up before the pll
  wire pll_enable_d = clock_multiplier_control_q[`ACR_PLL_EN_BIT];
  wire reference_enable_d = clock_multiplier_control_q[`ACR_REF_EN_BIT];
  wire [1:0] sample_clock_select_d =
    (sample_code == `ACR_CLK_RESERVED) ? sample_clock_select : sample_code;
  wire [1:0] metering_clock_select_d =
    (metering_code == `ACR_CLK_RESERVED) ? metering_clock_select : metering_code;
  wire [1:0] processor_clock_select_d = processor_code;
  // 00 none, 01 x2, 11 x4; bit 7 alone has no effect
  wire [1:0] processor_clock_boost_d = {quad_req & double_req, double_req};
  wire grid_frequency_select_d = pll_grid_control_q[`ACR_GRID_BIT];
  wire irq_d = |(irq_status_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // write address: address and data are taken in either order, one write at a time
  always @(posedge ref_clk) begin
    if (srst) begin
      aw_held_q <= 1'b0;
      s_axi_awready <= 1'b0;
      awaddr_q <= {`ACR_ADDR_W{1'b0}};
    end else begin
      s_axi_awready <= 1'b0;
      if (s_axi_awvalid && !aw_held_q && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
      end
    end
  end

  // write data: held until the matching address is there as well
  always @(posedge ref_clk) begin
    if (srst) begin
      w_held_q <= 1'b0;
      s_axi_wready <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      s_axi_wready <= 1'b0;
      if (s_axi_wvalid && !w_held_q && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // write response: a new write waits until the previous answer is taken
  always @(posedge ref_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ACR_RESP_OKAY;
    end else begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        case (w_idx)
          `ACR_IDX_ADC_EN, `ACR_IDX_AUX_CHOP, `ACR_IDX_REG_CTRL, `ACR_IDX_CLK_MUL,
          `ACR_IDX_PLL_GRID, `ACR_IDX_IRQ_MASK, `ACR_IDX_STATUS,
          `ACR_IDX_IRQ_STAT: begin
            s_axi_bresp <= `ACR_RESP_OKAY; // status write ignored
          end
          default: begin
            s_axi_bresp <= `ACR_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers; reserved bits are stored as written except in the interrupt mask, software keeps them
  always @(posedge ref_clk) begin
    if (srst) begin
      adc_enable_control_q <= `ACR_CTRL_RESET;
      aux_channel_chopper_control_q <= `ACR_CTRL_RESET;
      regulator_control_q <= `ACR_CTRL_RESET;
      clock_multiplier_control_q <= `ACR_CTRL_RESET;
      pll_grid_control_q <= `ACR_CTRL_RESET;
      irq_mask_q <= {`ACR_EV_W{1'b0}};
    end else if (wr_lane0) begin
      case (w_idx)
        `ACR_IDX_ADC_EN: adc_enable_control_q <= wdata_q[7:0];
        `ACR_IDX_AUX_CHOP: aux_channel_chopper_control_q <= wdata_q[7:0];
        `ACR_IDX_REG_CTRL: regulator_control_q <= wdata_q[7:0];
        `ACR_IDX_CLK_MUL: clock_multiplier_control_q <= wdata_q[7:0];
        `ACR_IDX_PLL_GRID: pll_grid_control_q <= wdata_q[7:0];
        `ACR_IDX_IRQ_MASK: irq_mask_q <= wdata_q[`ACR_EV_W-1:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read address: one read at a time, answer two edges after arvalid
  always @(posedge ref_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    end
  end

  // read data: taken at the address handshake, so a read-clear and its data agree
  always @(posedge ref_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ACR_RESP_OKAY;
    end else begin
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `ACR_RESP_OKAY;
        case (r_idx)
          `ACR_IDX_ADC_EN: s_axi_rdata <= {24'h000000, adc_enable_control_q};
          `ACR_IDX_AUX_CHOP: s_axi_rdata <= {24'h000000, aux_channel_chopper_control_q};
          `ACR_IDX_REG_CTRL: s_axi_rdata <= {24'h000000, regulator_control_q};
          `ACR_IDX_CLK_MUL: s_axi_rdata <= {24'h000000, clock_multiplier_control_q};
          `ACR_IDX_PLL_GRID: s_axi_rdata <= {24'h000000, pll_grid_control_q};
          `ACR_IDX_STATUS: s_axi_rdata <= {24'h000000, status_value};
          `ACR_IDX_IRQ_STAT: s_axi_rdata <= {{(32-`ACR_EV_W){1'b0}}, irq_status_q};
          `ACR_IDX_IRQ_MASK: s_axi_rdata <= {{(32-`ACR_EV_W){1'b0}}, irq_mask_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ACR_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky events; a new event in the read-clear cycle survives
  genvar gi;
  generate
    for (gi = 0; gi < `ACR_EV_W; gi = gi + 1) begin : g_ev
      always @(posedge ref_clk) begin
        if (srst) begin
          irq_status_q[gi] <= 1'b0;
        end else if (events[gi]) begin
          irq_status_q[gi] <= 1'b1;
        end else if (read_stat) begin
          irq_status_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // previous levels reset low: a comparator already high after reset reports one rise
  always @(posedge ref_clk) begin
    if (srst) begin
      crystal_prev_q <= 1'b0;
      cmp_prev_q <= 1'b0;
    end else begin
      crystal_prev_q <= crystal_stopped_in;
      cmp_prev_q <= comparator_out_in;
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog outputs, registered once more from the control registers
  always @(posedge ref_clk) begin
    if (srst) begin
      comparator_enable <= 1'b0;
      aux_adc_enable <= 1'b0;
      voltage_adc_enable <= 1'b0;
      current_b_adc_enable <= 1'b0;
      current_a_adc_enable <= 1'b0;
      aux_chopper_disable <= 1'b0;
      power_detect_disable <= 1'b0;
      regulator_bias_boost <= 1'b0;
      regulator_voltage_select <= 3'h0;
      digital_supply_trim <= 3'h0;
      pll_enable <= 1'b0;
      reference_enable <= 1'b0;
      sample_clock_select <= 2'h0;
      metering_clock_select <= 2'h0;
      processor_clock_select <= 2'h0;
      processor_clock_boost <= 2'h0;
      grid_frequency_select <= 1'b0;
    end else begin
      comparator_enable <= comparator_enable_d;
      aux_adc_enable <= aux_adc_enable_d;
      voltage_adc_enable <= voltage_adc_enable_d;
      current_b_adc_enable <= current_b_adc_enable_d;
      current_a_adc_enable <= current_a_adc_enable_d;
      aux_chopper_disable <= aux_chopper_disable_d;
      power_detect_disable <= power_detect_disable_d;
      regulator_bias_boost <= regulator_bias_boost_d;
      regulator_voltage_select <= regulator_voltage_select_d;
      digital_supply_trim <= digital_supply_trim_d;
      pll_enable <= pll_enable_d;
      reference_enable <= reference_enable_d;
      sample_clock_select <= sample_clock_select_d;
      metering_clock_select <= metering_clock_select_d;
      processor_clock_select <= processor_clock_select_d;
      processor_clock_boost <= processor_clock_boost_d;
      grid_frequency_select <= grid_frequency_select_d;
    end
  end

endmodule // acr_bank

// ### verification/acr_bank_asserts.sv
// acr_bank_asserts.sv: port-level checks of the analog control register bank
// assumes one clock ref_clk and synchronous active-high srst
`timescale 1ns/1ps
`include "acr_map.vh"
module acr_bank_asserts (
  // clock and reset
  input wire ref_clk,
  input wire srst,
  // bus
  input wire [`ACR_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_awready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // controls
  input wire comparator_enable,
  input wire pll_enable,
  input wire [1:0] sample_clock_select,
  input wire [1:0] metering_clock_select,
  input wire [1:0] processor_clock_boost,
  input wire irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // remembers which word the pending read answers
  reg [`ACR_ADDR_W-1:0] rd_addr_q;
  always @(posedge ref_clk) if (s_axi_arvalid && s_axi_arready) rd_addr_q <= s_axi_araddr;
  ////////////////////////////////////////////////////////////////////////////
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped early");
  property p_awpulse; s_axi_awready |=> !s_axi_awready; endproperty
  a_awpulse: assert property (p_awpulse) else $error("address ready held");
  property p_status; s_axi_rvalid && rd_addr_q == {`ACR_IDX_STATUS, 2'b00}
    |-> s_axi_rdata[4:2] == 3'h5 && s_axi_rdata[31:8] == 24'h0; endproperty
  a_status: assert property (p_status) else $error("status pattern wrong");
  property p_rst; $past(srst) |-> !comparator_enable && !pll_enable && !irq; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_boost; processor_clock_boost != 2'b10; endproperty
  a_boost: assert property (p_boost) else $error("second doubling without first");
  property p_code3; sample_clock_select != 2'b11 && metering_clock_select != 2'b11; endproperty
  a_code3: assert property (p_code3) else $error("reserved clock code applied");
  property p_cmp; $rose(comparator_enable) |-> $past(s_axi_bvalid); endproperty
  a_cmp: assert property (p_cmp) else $error("comparator enabled without a write");
endmodule // acr_bank_asserts

bind acr_bank acr_bank_asserts acr_bank_asserts_i (.ref_clk(ref_clk), .srst(srst),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .comparator_enable(comparator_enable), .pll_enable(pll_enable),
  .sample_clock_select(sample_clock_select), .metering_clock_select(metering_clock_select),
  .processor_clock_boost(processor_clock_boost), .irq(irq));

// ### verification/acr_bank_tb_top.sv
// acr_bank_tb_top.sv: self-checking bench for the register bank with a bench model
// assumes the checker is bound by its own file
`timescale 1ns/1ps
`include "acr_map.vh"
module acr_bank_tb_top;
  localparam [1:0] OK = 2'b00, SE = 2'b10;
  localparam [39:0] WMASK = 40'he0ffff012f;
  reg ref_clk = 1'b0, srst = 1'b1;
  reg [17:0] s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0;
  reg [31:0] s_axi_wdata = 32'h0, rd_d;
  reg [3:0] s_axi_wstrb = 4'h0;
  reg [1:0] rd_r;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg crystal_stopped_in = 1'b0, comparator_out_in = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire comparator_enable, aux_adc_enable, voltage_adc_enable, current_b_adc_enable;
  wire current_a_adc_enable, aux_chopper_disable, power_detect_disable, regulator_bias_boost;
  wire pll_enable, reference_enable, grid_frequency_select;
  wire [2:0] regulator_voltage_select, digital_supply_trim;
  wire [1:0] sample_clock_select, metering_clock_select, processor_clock_select;
  wire [1:0] processor_clock_boost;
  wire [4:0] adc_o = {comparator_enable, aux_adc_enable, voltage_adc_enable,
    current_b_adc_enable, current_a_adc_enable};
  wire [7:0] rgl_o = {power_detect_disable, regulator_bias_boost, regulator_voltage_select,
    digital_supply_trim};
  wire [9:0] clk_o = {pll_enable, reference_enable, sample_clock_select, metering_clock_select,
    processor_clock_select};
  wire [2:0] pll_o = {processor_clock_boost, grid_frequency_select};
  int m[5], smp, met, i, d, xt, cp, num_errors = 0, samples_checked = 0;
  integer seed = 32'haeac;
  acr_bank acr_bank_i (.ref_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .crystal_stopped_in, .comparator_out_in, .comparator_enable,
    .aux_adc_enable, .voltage_adc_enable, .current_b_adc_enable, .current_a_adc_enable,
    .aux_chopper_disable, .power_detect_disable, .regulator_bias_boost,
    .regulator_voltage_select, .digital_supply_trim, .pll_enable, .reference_enable,
    .sample_clock_select, .metering_clock_select, .processor_clock_select,
    .processor_clock_boost, .grid_frequency_select, .irq);
  always #2.5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  task check_value(input [31:0] seen, input [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // response ready comes late at random so the slave must hold its answer
  task wr(input [15:0] idx, input [31:0] wd, input [3:0] st, input [1:0] er);
    int n, dly;
    n = 0;
    dly = {$random(seed)} % 8;
    @(posedge ref_clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= wd;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n >= dly && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    check_value(s_axi_bresp, er);
  endtask
  task rd(input [15:0] idx);
    int n, dly;
    n = 0;
    dly = {$random(seed)} % 8;
    @(posedge ref_clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n >= dly && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task outs;
    repeat (2) @(posedge ref_clk);
    check_value(adc_o, {m[0][5], m[0][3:0]});
    check_value(aux_chopper_disable, m[1][0]);
    check_value(rgl_o, m[2][7:0]);
    check_value(clk_o, {m[3][7:6], smp[1:0], met[1:0], m[3][1:0]});
    check_value(pll_o, {m[4][7] & m[4][6], m[4][6], m[4][5]});
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(20000 * 5);
    num_errors++;
    complete_run;
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    for (i = 0; i < 5; i++) begin
      m[i] = 0;
      rd(16'h2864 + i[15:0]);
      check_value(rd_d, 0);
    end
    smp = 0;
    met = 0;
    outs;
    $display("test reset values done");
    repeat (40) begin
      i = {$random(seed)} % 5;
      d = $random(seed) & WMASK[8*i +: 8];
      wr(16'h2864 + i[15:0], d, 4'hf, OK);
      m[i] = d;
      if (i == 3 && d[5:4] != 2'b11) smp = d[5:4];
      if (i == 3 && d[3:2] != 2'b11) met = d[3:2];
      rd(16'h2864 + i[15:0]);
      check_value(rd_d, d);
      outs;
    end
    $display("test random writes done");
    wr(16'h2864, 32'h2f, 4'he, OK);
    rd(16'h2864);
    check_value(rd_d, m[0]);
    wr(16'h2869, 32'h1, 4'hf, SE);
    rd(16'h2869);
    check_value(rd_r, SE);
    check_value(rd_d, 32'h0);
    wr(`ACR_IDX_STATUS, 32'hff, 4'hf, OK);
    repeat (6) begin
      xt = $random(seed);
      cp = $random(seed);
      crystal_stopped_in <= xt[0];
      comparator_out_in <= cp[0];
      repeat (2) @(posedge ref_clk);
      rd(`ACR_IDX_STATUS);
      check_value(rd_d, {24'h0, xt[0], 1'b0, cp[0], 5'b10100});
      check_value(rd_r, OK);
    end
    $display("test map and status done");
    crystal_stopped_in <= 1'b0;
    comparator_out_in <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(`ACR_IDX_IRQ_STAT);
    comparator_out_in <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check_value(irq, 1'b0);
    rd(`ACR_IDX_IRQ_STAT);
    check_value(rd_d, 32'h2);
    wr(`ACR_IDX_IRQ_MASK, 32'h7, 4'hf, OK);
    comparator_out_in <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check_value(irq, 1'b1);
    rd(`ACR_IDX_IRQ_STAT);
    check_value(rd_d, 32'h4);
    repeat (2) @(posedge ref_clk);
    check_value(irq, 1'b0);
    crystal_stopped_in <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check_value(irq, 1'b1);
    rd(`ACR_IDX_IRQ_STAT);
    check_value(rd_d, 32'h1);
    $display("test interrupts done");
    complete_run;
  end
endmodule // acr_bank_tb_top
